// *** hdl/tpc_buf_if.sv ***
// Carrier between the conversion logic and its result buffer.
interface tpc_buf_if #(parameter int WIDTH = 12);
   logic [WIDTH-1:0] in_data;
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] out_data;
   logic             out_valid;
   logic             out_ready;
   logic             flush;
   modport producer (output in_data, in_valid, out_ready, flush, input in_ready, out_data, out_valid);
   modport buffer   (input in_data, in_valid, out_ready, flush, output in_ready, out_data, out_valid);
endinterface

// *** hdl/tpc_defs.svh ***
// Named constants of the touch serial and power-control block.
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

`define TPC_DATA_BITS      12
`define TPC_LO_RES_BITS    8
`define TPC_MSB_IDX_HI     4'hB
`define TPC_MSB_IDX_LO     4'h7
`define TPC_LAST_IDX       4'h1
`define TPC_LO_PAD         4'h0
`define TPC_CNT_SER_BIT    3'h4
`define TPC_CNT_LAST_BIT   3'h6
`define TPC_CNT_ZERO       3'h0
`define TPC_BYTE_CH_HI     6
`define TPC_BYTE_CH_LO     4
`define TPC_BYTE_MODE      3
`define TPC_BYTE_SER       2
`define TPC_BYTE_PD1       1
`define TPC_BYTE_PD0       0
`define TPC_CH_Y_POS       3'h1
`define TPC_CH_Z1_POS      3'h3
`define TPC_CH_Z2_POS      3'h4
`define TPC_CH_X_POS       3'h5
`define TPC_SYNC_CS        0
`define TPC_SYNC_SCLK      1
`define TPC_SYNC_DIN       2
`define TPC_SYNC_XP        3
`define TPC_SYNC_BITS      4

`endif

// *** hdl/tpc_fifo2.sv ***
// Small result buffer with valid and ready on both sides.
module tpc_fifo2 #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic      clk,
   input wire logic      reset_n,
   // Buffer side of the carrier
   tpc_buf_if.buffer     bus
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW:0]      count_reg;
   wire              do_push = bus.in_valid & bus.in_ready;
   wire              do_pop  = bus.out_valid & bus.out_ready;
   wire [PW-1:0]     wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
   wire [PW-1:0]     rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

   assign bus.in_ready  = (count_reg != (PW+1)'(DEPTH));
   assign bus.out_valid = (count_reg != '0);
   assign bus.out_data  = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_reg[wr_ptr_reg] <= bus.in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (bus.flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_next;
         end
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_next;
         end
         count_reg <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
   end
endmodule

// *** hdl/tpc_pkg.sv ***
// Types shared by the touch serial and power-control block.
package tpc_pkg;
   typedef enum logic [1:0] {CV_OFF, CV_BUSY, CV_SHIFT} tpc_conv_state_type;
endpackage

// *** hdl/tpc_touch_ctrl.sv ***
// Serial conversion, pen-detect and power control of a resistive touch converter.
`include "tpc_defs.svh"

module tpc_touch_ctrl
   import tpc_pkg::*;
#(
   parameter int DATA_BITS = `TPC_DATA_BITS
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // Serial link pins
   input  wire logic                 cs_n_pin,
   input  wire logic                 serial_clock_in,
   input  wire logic                 serial_data_in,
   output logic                      serial_data_out,
   output logic                      serial_data_out_oe_n,
   output logic                      busy_out,
   output logic                      busy_oe_n,
   // Pen detect path
   input  wire logic                 x_plus_level,
   output logic                      pen_touch_irq_n,
   output logic                      pen_path_to_x_plus,
   output logic                      x_plus_pullup_on,
   output logic                      y_minus_drive_on,
   // Analog core control
   input  wire logic [DATA_BITS-1:0] sample_code,
   output logic [2:0]                channel_select,
   output logic                      sample_hold,
   output logic                      panel_drivers_on,
   output logic                      reference_mode_select,
   output logic                      resolution_8bit,
   output logic                      adc_powered,
   output logic                      reference_on
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection.

   logic [`TPC_SYNC_BITS-1:0] sync_1_reg;
   logic [`TPC_SYNC_BITS-1:0] sync_2_reg;
   logic                      sclk_prev_reg;
   logic                      cs_prev_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_1_reg    <= '1;
         sync_2_reg    <= '1;
         sclk_prev_reg <= 1'b1;
         cs_prev_reg   <= 1'b1;
      end else begin
         sync_1_reg    <= {x_plus_level, serial_data_in, serial_clock_in, cs_n_pin};
         sync_2_reg    <= sync_1_reg;
         sclk_prev_reg <= sync_2_reg[`TPC_SYNC_SCLK];
         cs_prev_reg   <= sync_2_reg[`TPC_SYNC_CS];
      end
   end

   wire cs_high   = sync_2_reg[`TPC_SYNC_CS];
   wire sclk_s    = sync_2_reg[`TPC_SYNC_SCLK];
   wire din_s     = sync_2_reg[`TPC_SYNC_DIN];
   wire xp_s      = sync_2_reg[`TPC_SYNC_XP];
   wire cs_rise   = cs_high & ~cs_prev_reg;
   wire cs_fall   = ~cs_high & cs_prev_reg;
   // Serial clock edges are ignored while chip select is high.
   wire sclk_rise = sclk_s & ~sclk_prev_reg & ~cs_high;
   wire sclk_fall = ~sclk_s & sclk_prev_reg & ~cs_high;

   ////////////////////////////////////////////////////////////////////////////
   // Control byte receiver, sampled on rising serial clock edges.

   logic       rx_active_reg;
   logic [2:0] rx_count_reg;
   logic [5:0] rx_shift_reg;
   logic       pending_reg;
   logic       acq_reg;
   logic [2:0] meas_chan_reg;
   logic       res8_reg;
   logic       ser_reg;
   logic       pd1_reg;
   logic       pd0_reg;

   wire [6:0] new_byte   = {rx_shift_reg, din_s};
   wire       start_seen = sclk_rise & ~rx_active_reg & din_s;
   wire       rx_step    = sclk_rise & rx_active_reg;
   wire       acq_start  = rx_step & (rx_count_reg == `TPC_CNT_SER_BIT);
   wire       byte_done  = rx_step & (rx_count_reg == `TPC_CNT_LAST_BIT);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_active_reg <= 1'b0;
         rx_count_reg  <= `TPC_CNT_ZERO;
         rx_shift_reg  <= '0;
      end else if (cs_rise) begin
         rx_active_reg <= 1'b0;
         rx_count_reg  <= `TPC_CNT_ZERO;
      end else if (start_seen) begin
         rx_active_reg <= 1'b1;
         rx_count_reg  <= `TPC_CNT_ZERO;
      end else if (rx_step) begin
         rx_active_reg <= ~byte_done;
         rx_count_reg  <= rx_count_reg + 3'h1;
         rx_shift_reg  <= new_byte[5:0];
      end
   end

   // Fields apply to the conversion that this byte starts.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         res8_reg <= 1'b0;
         ser_reg  <= 1'b1;
         pd1_reg  <= 1'b0;
         pd0_reg  <= 1'b1;
      end else if (byte_done) begin
         res8_reg <= new_byte[`TPC_BYTE_MODE];
         ser_reg  <= new_byte[`TPC_BYTE_SER];
         pd1_reg  <= new_byte[`TPC_BYTE_PD1];
         pd0_reg  <= new_byte[`TPC_BYTE_PD0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequence, advanced on falling serial clock edges.

   tpc_conv_state_type     conv_state_reg;
   tpc_conv_state_type     conv_state_next;
   logic [3:0]             bit_idx_reg;
   logic [DATA_BITS-1:0]   out_shift_reg;
   logic                   dout_reg;
   logic                   busy_reg;

   tpc_buf_if #(.WIDTH(DATA_BITS)) buf_bus ();

   tpc_fifo2 #(.WIDTH(DATA_BITS), .DEPTH(2)) u_result_buf (
      .clk     (clk),
      .reset_n (reset_n),
      .bus     (buf_bus.buffer)
   );

   // Stalls on a full buffer hold the conversion back rather than drop a word.
   wire conv_start = sclk_fall & pending_reg & buf_bus.in_ready;
   wire busy_end   = sclk_fall & ~conv_start & (conv_state_reg == CV_BUSY);
   wire shift_step = sclk_fall & ~conv_start & (conv_state_reg == CV_SHIFT);
   wire conv_end   = shift_step & (bit_idx_reg == `TPC_LAST_IDX);
   wire conv_on    = (conv_state_reg != CV_OFF);
   wire active     = acq_reg | pending_reg | conv_on;

   // Eight-bit results keep the top bits of the code, left aligned.
   assign buf_bus.in_valid  = conv_start;
   assign buf_bus.in_data   = res8_reg ? {sample_code[DATA_BITS-1 -: `TPC_LO_RES_BITS], `TPC_LO_PAD} : sample_code;
   assign buf_bus.out_ready = busy_end;
   assign buf_bus.flush     = cs_rise;

   always_comb begin
      conv_state_next = conv_state_reg;
      unique case (conv_state_reg)
         CV_OFF:   conv_state_next = CV_OFF;
         CV_BUSY:  conv_state_next = busy_end ? CV_SHIFT : CV_BUSY;
         CV_SHIFT: conv_state_next = conv_end ? CV_OFF : CV_SHIFT;
      endcase
      if (conv_start) begin
         conv_state_next = CV_BUSY;
      end
      if (cs_rise) begin
         conv_state_next = CV_OFF;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conv_state_reg <= CV_OFF;
         pending_reg    <= 1'b0;
         acq_reg        <= 1'b0;
         meas_chan_reg  <= '0;
      end else begin
         conv_state_reg <= conv_state_next;
         pending_reg    <= ~cs_rise & (byte_done | (pending_reg & ~conv_start));
         acq_reg        <= ~cs_rise & (acq_start | (acq_reg & ~conv_start));
         if (acq_start) begin
            meas_chan_reg <= rx_shift_reg[3:1];
         end
      end
   end

   // Busy and data change only on a detected falling edge or on chip select rising.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg      <= 1'b0;
         dout_reg      <= 1'b0;
         bit_idx_reg   <= '0;
         out_shift_reg <= '0;
      end else if (cs_rise) begin
         busy_reg <= 1'b0;
         dout_reg <= 1'b0;
      end else if (conv_start) begin
         busy_reg <= 1'b1;
      end else if (busy_end) begin
         busy_reg      <= 1'b0;
         out_shift_reg <= buf_bus.out_data;
         dout_reg      <= buf_bus.out_data[DATA_BITS-1];
         bit_idx_reg   <= res8_reg ? `TPC_MSB_IDX_LO : `TPC_MSB_IDX_HI;
      end else if (shift_step) begin
         out_shift_reg <= out_shift_reg << 1;
         dout_reg      <= out_shift_reg[DATA_BITS-2];
         bit_idx_reg   <= bit_idx_reg - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pen detect and power control.

   logic pen_enable_reg;
   logic initial_reg;
   logic ref_on_reg;
   logic oe_n_reg;
   logic irq_n_reg;
   logic path_reg;
   logic pullup_reg;
   logic drivers_reg;
   logic adc_on_reg;

   wire is_touch   = (meas_chan_reg == `TPC_CH_X_POS) | (meas_chan_reg == `TPC_CH_Y_POS) |
                     (meas_chan_reg == `TPC_CH_Z1_POS) | (meas_chan_reg == `TPC_CH_Z2_POS);
   wire meas_touch = active & is_touch;
   wire pen_path   = pen_enable_reg & ~active;
   wire irq_next   = active ? ~is_touch : (pen_path ? xp_s : 1'b1);
   wire drv_next   = is_touch & (acq_reg | (conv_on & ~ser_reg));
   // Chip select high powers down, except before the first auto power-down byte.
   wire pd_next    = ~initial_reg & (cs_high | (~pd0_reg & ~active));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pen_enable_reg <= 1'b0;
         initial_reg    <= 1'b1;
      end else begin
         if (byte_done & new_byte[`TPC_BYTE_PD0]) begin
            pen_enable_reg <= 1'b0;
         end else if (conv_end & ~pd0_reg) begin
            pen_enable_reg <= 1'b1;
         end
         if (byte_done & ~new_byte[`TPC_BYTE_PD0]) begin
            initial_reg <= 1'b0;
         end
      end
   end

   // The reference follows the byte only at busy rising; chip select never touches it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_on_reg <= 1'b0;
      end else if (conv_start) begin
         ref_on_reg <= pd1_reg;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oe_n_reg    <= 1'b1;
         irq_n_reg   <= 1'b1;
         path_reg    <= 1'b0;
         pullup_reg  <= 1'b1;
         drivers_reg <= 1'b0;
         adc_on_reg  <= 1'b1;
      end else begin
         oe_n_reg    <= cs_high;
         irq_n_reg   <= irq_next;
         path_reg    <= pen_path;
         pullup_reg  <= ~meas_touch;
         drivers_reg <= drv_next;
         adc_on_reg  <= ~pd_next;
      end
   end

   assign serial_data_out       = dout_reg;
   assign serial_data_out_oe_n  = oe_n_reg;
   assign busy_out              = busy_reg;
   assign busy_oe_n             = oe_n_reg;
   assign pen_touch_irq_n       = irq_n_reg;
   assign pen_path_to_x_plus    = path_reg;
   assign y_minus_drive_on      = path_reg;
   assign x_plus_pullup_on      = pullup_reg;
   assign channel_select        = meas_chan_reg;
   assign sample_hold           = acq_reg;
   assign panel_drivers_on      = drivers_reg;
   assign reference_mode_select = ser_reg;
   assign resolution_8bit       = res8_reg;
   assign adc_powered           = adc_on_reg;
   assign reference_on          = ref_on_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the sequence above.

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   busy_edge_a:  assert property ($changed(busy_reg) |-> $past(sclk_fall) || $past(cs_rise))
      else $error("busy changed without a falling edge");
   dout_edge_a:  assert property ($changed(dout_reg) |-> $past(sclk_fall) || $past(cs_rise))
      else $error("data out changed without a falling edge");
   oe_on_a:      assert property (cs_fall |=> !serial_data_out_oe_n && !busy_oe_n)
      else $error("drivers not enabled after chip select fell");
   abort_a:      assert property (cs_rise |=> !busy_out && conv_state_reg == CV_OFF && !sample_hold)
      else $error("conversion not abandoned on chip select rise");
   irq_low_a:    assert property (meas_touch |=> !pen_touch_irq_n)
      else $error("irq not low during touch measurement");
   irq_high_a:   assert property (active && !is_touch |=> pen_touch_irq_n)
      else $error("irq not high during auxiliary measurement");
   pullup_off_a: assert property (meas_touch |=> !x_plus_pullup_on)
      else $error("pull-up left on during touch measurement");
   pen_low_a:    assert property (pen_path && !xp_s |=> !pen_touch_irq_n && y_minus_drive_on)
      else $error("touch not reported on irq");
   pen_route_a:  assert property (pen_path |=> y_minus_drive_on && pen_path_to_x_plus)
      else $error("pen path not set up in power-down");
   pen_off_a:    assert property (byte_done && din_s |=> !pen_enable_reg)
      else $error("pen detection kept after full-power byte");
   pen_on_a:     assert property (conv_end && !pd0_reg |=> pen_enable_reg ##1 pen_path_to_x_plus)
      else $error("pen detection not restored at end of conversion");
   ref_keep_a:   assert property (cs_rise |=> reference_on == $past(reference_on))
      else $error("reference changed by chip select");
   ref_latch_a:  assert property (conv_start |=> reference_on == $past(pd1_reg))
      else $error("reference not latched at busy rise");
   idx_load_a:   assert property (busy_end |=> bit_idx_reg == ($past(res8_reg) ? `TPC_MSB_IDX_LO : `TPC_MSB_IDX_HI))
      else $error("wrong result length loaded");
   msb_first_a:  assert property (busy_end |=> serial_data_out == $past(buf_bus.out_data[DATA_BITS-1]))
      else $error("first result bit is not the MSB");
   single_drv_a: assert property (conv_on && ser_reg && !acq_reg |=> !panel_drivers_on)
      else $error("drivers on during single-ended conversion");
   init_pwr_a:   assert property (initial_reg |=> adc_powered)
      else $error("powered down before first auto power-down byte");

   end12_c:   cover property (conv_end && !res8_reg);
   end8_c:    cover property (conv_end && res8_reg);
   overlap_c: cover property (byte_done && conv_state_reg == CV_SHIFT);
   abort_c:   cover property (cs_rise && conv_on);
endmodule

// *** verification/tpc_host_model.sv ***
// Serial master model that frames control bytes towards the touch converter.
module tpc_host_model (
   // Serial link pins
   output logic cs_n_pin,
   output logic serial_clock_in,
   output logic serial_data_in
);
   timeunit 1ns;
   timeprecision 100ps;

   ////////////////////////////////////////////////////////////
   initial begin
      cs_n_pin        = 1'b1;
      serial_clock_in = 1'b0;
      serial_data_in  = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // Chip select moves off the system clock grid, then settles before any clock.
   task automatic select(input logic lvl);
      #7 cs_n_pin = lvl;
      #113;
   endtask

   // The clock stands low outside frames; data changes only while the clock is low, before the first rise or at each fall, well after the sampling rise.
   task automatic send(input logic [31:0] bits, input int n);
      #9;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = bits[i];
         #80 serial_clock_in = 1'b1;
         #80 serial_clock_in = 1'b0;
      end
      serial_data_in = ~serial_data_in;
   endtask
endmodule

// *** verification/tpc_touch_ctrl_tb.sv ***
// Self-checking bench for the touch serial and power-control block.
module tpc_touch_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk, reset_n, cs_n_pin, serial_clock_in, serial_data_in, x_plus_level;
   logic        serial_data_out, serial_data_out_oe_n, busy_out, busy_oe_n, sample_hold;
   logic        pen_touch_irq_n, pen_path_to_x_plus, x_plus_pullup_on, y_minus_drive_on;
   logic        panel_drivers_on, reference_mode_select, resolution_8bit, adc_powered, reference_on;
   logic [11:0] sample_code;
   logic [2:0]  channel_select;
   logic [12:0] exp_q[$];
   int          err_total = 0;
   int          n_compared = 0;
   int          seed = 23;

   ////////////////////////////////////////////////////////////
   tpc_touch_ctrl u_dut (
      .clk(clk), .reset_n(reset_n), .cs_n_pin(cs_n_pin), .serial_clock_in(serial_clock_in),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_out_oe_n(serial_data_out_oe_n), .busy_out(busy_out), .busy_oe_n(busy_oe_n),
      .x_plus_level(x_plus_level), .pen_touch_irq_n(pen_touch_irq_n),
      .pen_path_to_x_plus(pen_path_to_x_plus), .x_plus_pullup_on(x_plus_pullup_on),
      .y_minus_drive_on(y_minus_drive_on), .sample_code(sample_code), .channel_select(channel_select),
      .sample_hold(sample_hold), .panel_drivers_on(panel_drivers_on),
      .reference_mode_select(reference_mode_select), .resolution_8bit(resolution_8bit),
      .adc_powered(adc_powered), .reference_on(reference_on)
   );

   tpc_host_model u_host (
      .cs_n_pin(cs_n_pin), .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // Sends one control byte and notes the result it must produce.
   task automatic conv(input logic [2:0] ch, input logic m8, input logic ser, input logic [1:0] pd);
      tick(1);
      sample_code = 12'($random(seed));
      exp_q.push_back({m8, m8 ? {4'h0, sample_code[11:4]} : sample_code});
      u_host.send({24'h00_0000, 1'b1, ch, m8, ser, pd}, 8);
   endtask

   ////////////////////////////////////////////////////////////
   // Bits are taken mid-way through the high phase, clear of the update after each fall.
   initial begin
      logic [11:0] word;
      int          left;
      left = 0;
      word = 12'h000;
      forever begin
         @(posedge serial_clock_in);
         #40;
         if (left > 0) begin
            word = {word[10:0], serial_data_out};
            left--;
            if (left == 0) begin
               check(word, exp_q[0][11:0]);
               void'(exp_q.pop_front());
            end
         end else if (busy_out === 1'b1 && exp_q.size() > 0) begin
            // An eight-bit result must not carry bits left over from the previous word.
            word = 12'h000;
            left = exp_q[0][12] ? 8 : 12;
         end
      end
   end

   initial begin
      #1_000_000;
      err_total++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////
   // The pen line is judged both while idle and while a conversion is under way.
   initial begin
      logic [2:0] ch;
      reset_n      = 1'b0;
      x_plus_level = 1'b1;
      sample_code  = 12'h000;
      tick(2);
      reset_n = 1'b1;
      tick(2);
      check({adc_powered, reference_on, serial_data_out_oe_n}, 3'b101);
      u_host.select(1'b0);
      tick(4);
      check({busy_oe_n, serial_data_out_oe_n}, 2'b00);
      for (int i = 0; i < 16; i++) begin
         conv(3'($random(seed)), i[0], 1'($random(seed)), i[2:1]);
         u_host.send(32'h0000_0000, (i < 8) ? 8 : (i[0] ? 3 : 7));
      end
      conv(3'h5, 1'b0, 1'b0, 2'b10);
      u_host.send(32'h0000_0000, 13);
      tick(8);
      check(reference_on, 1'b1);
      check({pen_path_to_x_plus, y_minus_drive_on}, 2'b11);
      x_plus_level = 1'b0;
      tick(6);
      check(pen_touch_irq_n, 1'b0);
      u_host.select(1'b1);
      tick(6);
      check({reference_on, adc_powered, serial_data_out_oe_n}, 3'b101);
      x_plus_level = 1'b1;
      u_host.select(1'b0);
      for (int j = 0; j < 8; j++) begin
         ch = j[2] ? 3'h5 : 3'h2;
         conv(ch, j[0], j[1], 2'b00);
         u_host.send(32'h0000_0000, 1);
         tick(50);
         check(pen_touch_irq_n, !j[2]);
         if (j[2]) check(x_plus_pullup_on, 1'b0);
         check(panel_drivers_on, j[2] & !j[1]);
         check(adc_powered, 1'b1);
         check(channel_select, ch);
         check({reference_mode_select, resolution_8bit}, 2'(j[1:0]));
         u_host.send(32'h0000_0000, 12);
      end
      tick(8);
      check(reference_on, 1'b0);
      conv(3'h0, 1'b1, 1'b1, 2'b01);
      u_host.send(32'h0000_0000, 9);
      u_host.select(1'b1);
      tick(1);
      x_plus_level = 1'b0;
      tick(8);
      check(pen_touch_irq_n, 1'b1);
      u_host.select(1'b0);
      conv(3'h0, 1'b0, 1'b1, 2'b00);
      u_host.send(32'h0000_0000, 13);
      tick(8);
      check(pen_touch_irq_n, 1'b0);
      check(12'(exp_q.size()), 12'h000);
      give_verdict();
   end
endmodule
